// *** bench/spm_mux_tb.sv ***
`timescale 1ns/10ps
module spm_mux_tb;
	import spm_pkg::*;
	logic clk, rst, ce, irq_en, rst_en, timer_ext_clock_en, xtal, osc_en, osc_clk, osci_en;
	logic timer_ext_clock_in, irq_n, rst_n, osc_in;
	logic [5:0] pad_in, pad_out, pad_oe, ext, key_en, dir, gout, gin, kin;
	logic [3:0] an_en, an_sel;
	logic [1:0] tm_en, tm_oe, tm_out, tm_in;
	logic [17:0] pin_func, exp_f;
	logic [31:0] seed;
	logic [63:0] r;
	int error_cnt, checks_done, cyc;
	spm_fn_t own [6];
	spm_mux DUT (.CLK(clk), .RESET(rst), .CE(ce), .PAD_IN(pad_in), .PAD_OUT(pad_out),
		.PAD_OE(pad_oe), .ANALOG_EN(an_en), .TIMER_EN(tm_en), .TIMER_OUT_EN(tm_oe),
		.TIMER_OUT(tm_out), .KEYPAD_EN(key_en), .IRQ_EN(irq_en), .RESET_PIN_EN(rst_en),
		.TIMER_EXT_CLOCK_EN(timer_ext_clock_en), .OSC_XTAL_MODE(xtal), .OSC_OUT_ENABLE(osc_en),
		.OSC_CLK_OUT(osc_clk), .OSC_IN_EN(osci_en), .GPIO_DIR(dir), .GPIO_OUT(gout),
		.GPIO_IN(gin), .KEYPAD_IN(kin), .ANALOG_SEL(an_sel), .TIMER_CHAN_IN(tm_in),
		.TIMER_CLK_IN(timer_ext_clock_in), .IRQ_IN_N(irq_n), .RESET_PIN_N(rst_n), .OSC_IN(osc_in),
		.PIN_FUNC(pin_func));
	spm_pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));
	////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			summarize;
		end
	end
	////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// all function enables, port controls and outside levels in one go
	task automatic apply(input logic [40:0] v);
		{an_en, tm_en, tm_oe, tm_out, key_en, irq_en, rst_en, timer_ext_clock_en, xtal, osc_en,
			osc_clk, osci_en, dir, gout, ext} <= v;
	endtask
	function automatic spm_fn_t pick(input logic a, input spm_fn_t fa, input logic b,
		input spm_fn_t fb, input logic c, input spm_fn_t fc);
		return spm_fn_t'(a ? fa : b ? fb : c ? fc : FN_GPIO);
	endfunction
	// expected owners, pad drive and routed levels from the ranking
	task automatic check_all;
		logic [5:0] oe, o, pad, gi, ki;
		own[0] = pick(an_en[0], FN_ANALOG, tm_en[0], FN_TIMER, key_en[0], FN_KEYPAD);
		own[1] = pick(an_en[1], FN_ANALOG, tm_en[1], FN_TIMER, key_en[1], FN_KEYPAD);
		own[2] = pick(irq_en, FN_IRQ, key_en[2], FN_KEYPAD, timer_ext_clock_en, FN_TIMER_EXT_CLOCK);
		own[3] = pick(rst_en, FN_RESET, key_en[3], FN_KEYPAD, 1'b0, FN_GPIO);
		own[4] = pick(xtal | osc_en, FN_OSC, an_en[2], FN_ANALOG, key_en[4], FN_KEYPAD);
		own[5] = pick(osci_en, FN_OSC, an_en[3], FN_ANALOG, key_en[5], FN_KEYPAD);
		for (int p = 0; p < 6; p++) begin
			exp_f[3*p +: 3] = own[p];
			oe[p] = (own[p] == FN_GPIO && p != 2) ? dir[p] : (own[p] == FN_TIMER) ?
				tm_oe[p%2] : (own[p] == FN_OSC && p == 4);
			o[p] = (own[p] == FN_TIMER) ? tm_out[p%2] : (own[p] == FN_OSC) ? osc_clk : gout[p];
			pad[p] = oe[p] ? o[p] : ext[p];
			gi[p] = (own[p] == FN_GPIO) & pad[p];
			ki[p] = (own[p] == FN_KEYPAD) & pad[p];
		end
		check(pin_func, exp_f);
		check(pad_oe, oe);
		check(pad_out & oe, o & oe);
		check(gin, gi);
		check(kin, ki);
		check(an_sel, {own[5] == FN_ANALOG, own[4] == FN_ANALOG, own[1] == FN_ANALOG,
			own[0] == FN_ANALOG});
		check({irq_n, rst_n}, {own[2] != FN_IRQ | ext[2], own[3] != FN_RESET | ext[3]});
		check({tm_in, timer_ext_clock_in, osc_in}, {(own[1] == FN_TIMER) & pad[1], (own[0] == FN_TIMER) &
			pad[0], (own[2] == FN_TIMER_EXT_CLOCK) & ext[2], (own[5] == FN_OSC) & ext[5]});
	endtask
	// reset held, then the first edge after release keeps plain inputs
	task automatic do_reset;
		@(posedge clk) rst <= 1'b1;
		repeat (20) @(posedge clk);
		#1 check({pad_oe, pin_func, irq_n, rst_n, gin}, 32'hC0);
		@(posedge clk) rst <= 1'b0;
		@(posedge clk);
		#1 check({pad_oe, pin_func}, 32'h0);
	endtask
	////////////////////////////////////////
	// main sequence: corners, random vectors, freeze, second reset
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		seed = 32'h44;
		cyc = 0;
		error_cnt = 0;
		checks_done = 0;
		apply('1);
		do_reset;
		for (int i = 0; i < 300; i++) begin
			repeat (32) seed = lfsr(seed);
			r[31:0] = seed;
			repeat (32) seed = lfsr(seed);
			r[63:32] = seed;
			@(posedge clk) apply(i == 0 ? '1 : i == 1 ? {35'h0, r[5:0]} : r[40:0]);
			repeat (4) @(posedge clk);
			#1 check_all;
			if (i == 150) begin
				@(posedge clk) ce <= 1'b0;
				apply(~r[40:0]);
				repeat (4) @(posedge clk);
				#1 check(pin_func, exp_f);
				@(posedge clk) ce <= 1'b1;
				repeat (4) @(posedge clk);
				#1 check_all;
				do_reset;
			end
		end
		summarize;
	end
endmodule

// *** bench/spm_pad_model.sv ***
`timescale 1ns/10ps
// outside world at the pads: a driven pad shows the block's level
module spm_pad_model (
	input wire logic [5:0] pad_out,
	input wire logic [5:0] pad_oe,
	input wire logic [5:0] ext_lvl,
	output logic [5:0] pad_in
);
	// resolve each pad from both drivers
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_lvl[i];
		end
	end
endmodule

// *** hw/spm_arb_if.sv ***
`timescale 1ns/10ps
// claims of one pin and the rank that wins
interface spm_arb_if;
	logic [2:0] claim;
	logic [1:0] pick;
	modport arb (input claim, output pick);
	modport user (output claim, input pick);
endinterface

// *** hw/spm_mux.sv ***
`timescale 1ns/10ps
// Contract
// - after any reset every shared pin is a plain input port, whatever is enabled.
// - pin 0 ranks analog channel 0, timer channel 0, keypad input 0, then plain port.
// - pin 1 ranks analog channel 1, timer channel 1, keypad input 1, then plain port.
// - pin 2 ranks external interrupt, keypad input 2, timer external clock, then plain input.
// - pin 3 ranks the active-low reset input, keypad input 3, then plain port.
// - pin 4 ranks oscillator output, analog channel 2, keypad input 4, then plain port.
// - pin 5 ranks oscillator input, analog channel 3, keypad input 5, then plain port.
// - pin 2 as plain port is input only and is never driven.
// - oscillator output for RC or internal oscillator drives pin 4 only when its enable is 1.
module spm_mux (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [5:0] PAD_IN,
	output logic [5:0] PAD_OUT,
	output logic [5:0] PAD_OE,
	input wire logic [3:0] ANALOG_EN,
	input wire logic [1:0] TIMER_EN,
	input wire logic [1:0] TIMER_OUT_EN,
	input wire logic [1:0] TIMER_OUT,
	input wire logic [5:0] KEYPAD_EN,
	input wire logic IRQ_EN,
	input wire logic RESET_PIN_EN,
	input wire logic TIMER_EXT_CLOCK_EN,
	input wire logic OSC_XTAL_MODE,
	input wire logic OSC_OUT_ENABLE,
	input wire logic OSC_CLK_OUT,
	input wire logic OSC_IN_EN,
	input wire logic [5:0] GPIO_DIR,
	input wire logic [5:0] GPIO_OUT,
	output logic [5:0] GPIO_IN,
	output logic [5:0] KEYPAD_IN,
	output logic [3:0] ANALOG_SEL,
	output logic [1:0] TIMER_CHAN_IN,
	output logic TIMER_CLK_IN,
	output logic IRQ_IN_N,
	output logic RESET_PIN_N,
	output logic OSC_IN,
	output logic [17:0] PIN_FUNC
);
	import spm_pkg::*;

	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic live;
		logic [5:0] pad_out;
		logic [5:0] pad_oe;
		logic [5:0] gpio_in;
		logic [5:0] kbd_in;
		logic [3:0] analog_sel;
		logic [1:0] tch_in;
		logic timer_ext_clock;
		logic irq_n;
		logic rst_n;
		logic osc_in;
		logic [5:0][2:0] func;
	} spm_state_t;

	spm_state_t st_q;
	spm_state_t st_d;
	logic osc_out_claim;
	logic [SPM_FN_COUNT-1:0][5:0] en_by_fn;
	spm_fn_t grant [SPM_PINS];

	////////////////////////////////////////////////////////////////////////
	// claims per function and pin
	assign osc_out_claim = OSC_XTAL_MODE | OSC_OUT_ENABLE;
	always_comb begin
		en_by_fn = '0; // plain port never claims, it is the fallback
		en_by_fn[FN_ANALOG] = {ANALOG_EN[3], ANALOG_EN[2], 2'h0, ANALOG_EN[1:0]};
		en_by_fn[FN_TIMER] = {4'h0, TIMER_EN};
		en_by_fn[FN_KEYPAD] = KEYPAD_EN;
		en_by_fn[FN_IRQ][SPM_PIN_IRQ] = IRQ_EN;
		en_by_fn[FN_RESET][SPM_PIN_RESET] = RESET_PIN_EN;
		en_by_fn[FN_TIMER_EXT_CLOCK][SPM_PIN_IRQ] = TIMER_EXT_CLOCK_EN;
		en_by_fn[FN_OSC][SPM_PIN_OSC_OUT] = osc_out_claim;
		en_by_fn[FN_OSC][SPM_PIN_OSC_IN] = OSC_IN_EN;
	end

	////////////////////////////////////////////////////////////////////////
	// one arbiter per pin
	generate
		for (genvar p = 0; p < SPM_PINS; p++) begin : g_pin
			spm_arb_if arb_bus ();
			for (genvar l = 0; l < SPM_LEVELS; l++) begin : g_lvl
				assign arb_bus.claim[l] = en_by_fn[SPM_PRIO[p][l]][p];
			end
			spm_pin_arb u_arb (
				.bus(arb_bus)
			);
			// lowest rank is the plain port
			assign grant[p] = spm_fn_t'((arb_bus.pick == SPM_PICK_NONE) ? FN_GPIO
				: SPM_PRIO[p][arb_bus.pick]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next state: sync, routing, pad drive
	always_comb begin
		st_d = st_q;
		st_d.sync1 = PAD_IN;
		st_d.sync2 = st_q.sync1;
		st_d.live = 1'b1;
		st_d.kbd_in = '0;
		st_d.gpio_in = '0;
		st_d.analog_sel = '0;
		st_d.tch_in = '0;
		st_d.timer_ext_clock = 1'b0;
		st_d.irq_n = 1'b1;
		st_d.rst_n = 1'b1;
		st_d.osc_in = 1'b0;
		st_d.pad_out = '0;
		st_d.pad_oe = '0;
		for (int p = 0; p < SPM_PINS; p++) begin
			// first cycle after reset holds every pin as plain input
			st_d.func[p] = st_q.live ? grant[p] : FN_GPIO;
			case (spm_fn_t'(st_d.func[p]))
				FN_GPIO: begin
					st_d.gpio_in[p] = st_q.sync2[p];
					if (st_q.live && p != SPM_PIN_INPUT_ONLY) begin
						st_d.pad_oe[p] = GPIO_DIR[p];
						st_d.pad_out[p] = GPIO_OUT[p];
					end
				end
				FN_KEYPAD: begin
					st_d.kbd_in[p] = st_q.sync2[p];
				end
				default: begin
				end
			endcase
		end
		// pin-specific functions
		if (st_d.func[0] == FN_TIMER) begin
			st_d.tch_in[0] = st_q.sync2[0];
			st_d.pad_oe[0] = TIMER_OUT_EN[0];
			st_d.pad_out[0] = TIMER_OUT[0];
		end
		if (st_d.func[1] == FN_TIMER) begin
			st_d.tch_in[1] = st_q.sync2[1];
			st_d.pad_oe[1] = TIMER_OUT_EN[1];
			st_d.pad_out[1] = TIMER_OUT[1];
		end
		st_d.analog_sel[0] = (st_d.func[0] == FN_ANALOG);
		st_d.analog_sel[1] = (st_d.func[1] == FN_ANALOG);
		st_d.analog_sel[2] = (st_d.func[4] == FN_ANALOG);
		st_d.analog_sel[3] = (st_d.func[5] == FN_ANALOG);
		if (st_d.func[SPM_PIN_IRQ] == FN_IRQ) begin
			st_d.irq_n = st_q.sync2[SPM_PIN_IRQ];
		end
		if (st_d.func[SPM_PIN_IRQ] == FN_TIMER_EXT_CLOCK) begin
			st_d.timer_ext_clock = st_q.sync2[SPM_PIN_IRQ];
		end
		if (st_d.func[SPM_PIN_RESET] == FN_RESET) begin
			st_d.rst_n = st_q.sync2[SPM_PIN_RESET];
		end
		if (st_d.func[SPM_PIN_OSC_OUT] == FN_OSC) begin
			st_d.pad_oe[SPM_PIN_OSC_OUT] = 1'b1;
			st_d.pad_out[SPM_PIN_OSC_OUT] = OSC_CLK_OUT;
		end
		if (st_d.func[SPM_PIN_OSC_IN] == FN_OSC) begin
			st_d.osc_in = st_q.sync2[SPM_PIN_OSC_IN];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register, frozen while CE is low
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			st_q <= '{irq_n: 1'b1, rst_n: 1'b1, default: '0};
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign PAD_OUT = st_q.pad_out;
	assign PAD_OE = st_q.pad_oe;
	assign GPIO_IN = st_q.gpio_in;
	assign KEYPAD_IN = st_q.kbd_in;
	assign ANALOG_SEL = st_q.analog_sel;
	assign TIMER_CHAN_IN = st_q.tch_in;
	assign TIMER_CLK_IN = st_q.timer_ext_clock;
	assign IRQ_IN_N = st_q.irq_n;
	assign RESET_PIN_N = st_q.rst_n;
	assign OSC_IN = st_q.osc_in;
	assign PIN_FUNC = st_q.func;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	AST_RESET_INPUT: assert property (!st_q.live && CE |=> PAD_OE == '0 && PIN_FUNC == '0)
		else $error("pins not plain inputs after reset");
	AST_PIN0_ORDER: assert property (st_q.live && CE && ANALOG_EN[0]
		|=> PIN_FUNC[2:0] == FN_ANALOG && PAD_OE[0] == 1'b0)
		else $error("pin 0 analog not granted");
	AST_PIN1_ORDER: assert property (st_q.live && CE && !ANALOG_EN[1] && TIMER_EN[1]
		|=> PIN_FUNC[5:3] == FN_TIMER && PAD_OE[1] == $past(TIMER_OUT_EN[1]))
		else $error("pin 1 timer not granted");
	AST_PIN2_ORDER: assert property (st_q.live && CE && !IRQ_EN && KEYPAD_EN[2]
		|=> PIN_FUNC[8:6] == FN_KEYPAD && TIMER_CLK_IN == 1'b0)
		else $error("pin 2 keypad not above timer clock");
	// reset input follows the synchronised pin one edge after its claim is seen
	AST_PIN3_ORDER: assert property (st_q.live && CE && RESET_PIN_EN
		|=> RESET_PIN_N == $past(st_q.sync2[3]) && KEYPAD_IN[3] == 1'b0)
		else $error("pin 3 reset input not routed");
	AST_PIN4_ORDER: assert property (st_q.live && CE && osc_out_claim
		|=> PIN_FUNC[14:12] == FN_OSC && PAD_OE[4] && !ANALOG_SEL[2])
		else $error("pin 4 oscillator output not granted");
	AST_PIN5_ORDER: assert property (st_q.live && CE && !OSC_IN_EN && ANALOG_EN[3]
		|=> PIN_FUNC[17:15] == FN_ANALOG && ANALOG_SEL[3])
		else $error("pin 5 analog not granted");
	AST_PIN2_NO_DRIVE: assert property (PAD_OE[2] == 1'b0)
		else $error("pin 2 driven");
	AST_OSC_OUT_GATE: assert property (CE && !OSC_XTAL_MODE && !OSC_OUT_ENABLE
		|=> PIN_FUNC[14:12] != FN_OSC)
		else $error("oscillator output without enable");
	AST_ONE_OWNER: assert property (CE && st_q.live && KEYPAD_EN[0] && !ANALOG_EN[0] && !TIMER_EN[0]
		|=> KEYPAD_IN[0] == $past(st_q.sync2[0]) && GPIO_IN[0] == 1'b0 && !PAD_OE[0])
		else $error("pin 0 owned by two functions");

	COV_TIMER_DRIVE: cover property (PIN_FUNC[2:0] == FN_TIMER && PAD_OE[0]);
	COV_IRQ_PIN: cover property (PIN_FUNC[8:6] == FN_IRQ);
	COV_OSC_PAIR: cover property (PIN_FUNC[14:12] == FN_OSC && PIN_FUNC[17:15] == FN_OSC);
	COV_GPIO_OUT: cover property (PIN_FUNC[11:9] == FN_GPIO && PAD_OE[3]);
endmodule

// *** hw/spm_pin_arb.sv ***
`timescale 1ns/10ps
// fixed-priority pick, bit 0 of claim ranks highest
module spm_pin_arb (
	spm_arb_if.arb bus
);
	import spm_pkg::*;

	// first claim wins, none means plain port
	always_comb begin
		if (bus.claim[0]) begin
			bus.pick = 2'h0;
		end else if (bus.claim[1]) begin
			bus.pick = 2'h1;
		end else if (bus.claim[2]) begin
			bus.pick = 2'h2;
		end else begin
			bus.pick = SPM_PICK_NONE;
		end
	end
endmodule

// *** hw/spm_pkg.sv ***
package spm_pkg;
	// functions that can own a shared pin
	typedef enum logic [2:0] {
		FN_GPIO = 3'h0,
		FN_ANALOG = 3'h1,
		FN_TIMER = 3'h2,
		FN_KEYPAD = 3'h3,
		FN_IRQ = 3'h4,
		FN_RESET = 3'h5,
		FN_TIMER_EXT_CLOCK = 3'h6,
		FN_OSC = 3'h7
	} spm_fn_t;

	localparam int SPM_PINS = 6;
	localparam int SPM_LEVELS = 3;
	localparam int SPM_FN_COUNT = 8;
	localparam int SPM_ANALOG_CHANS = 4;
	localparam int SPM_TIMER_CHANS = 2;
	// pin positions of the single-pin functions
	localparam int SPM_PIN_IRQ = 2;
	localparam int SPM_PIN_RESET = 3;
	localparam int SPM_PIN_OSC_OUT = 4;
	localparam int SPM_PIN_OSC_IN = 5;
	localparam int SPM_PIN_INPUT_ONLY = 2;
	// arbiter answer meaning no claim, pin falls to plain port
	localparam logic [1:0] SPM_PICK_NONE = 2'h3;

	// ranking per pin, index 0 is the highest claimant above plain port
	localparam spm_fn_t SPM_PRIO [SPM_PINS][SPM_LEVELS] = '{
		'{FN_ANALOG, FN_TIMER, FN_KEYPAD},
		'{FN_ANALOG, FN_TIMER, FN_KEYPAD},
		'{FN_IRQ, FN_KEYPAD, FN_TIMER_EXT_CLOCK},
		'{FN_RESET, FN_KEYPAD, FN_GPIO},
		'{FN_OSC, FN_ANALOG, FN_KEYPAD},
		'{FN_OSC, FN_ANALOG, FN_KEYPAD}
	};
endpackage
